// ==== rtl/wsps_pkg.sv ====
/*
 * Shared constants and types of the wait/stop power-saving sequencer.
 * Assumes a single main clock and an 8-bit data-space write port from the core.
 */
package wsps_pkg;

    // ************************************************
    // interrupt option register
    // ************************************************
    localparam logic [7:0] IOR_ADDR = 8'hc8;
    localparam int GEN_BIT = 4;
    localparam logic GEN_RST = 1'b0;

    // ************************************************
    // timing
    // ************************************************
    // plain default; size it to the slowest resonator in use
    localparam int SETTLE_CYC = 4096;
    localparam int SYNC_STAGES = 2;

    // ************************************************
    // enumerations
    // ************************************************
    typedef enum logic [1:0] {
        CTX_MAIN = 2'b00,
        CTX_IRQ = 2'b01,
        CTX_NMI = 2'b10
    } wsps_ctx_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_STOP = 2'b10,
        ST_SETTLE = 2'b11
    } wsps_state_t;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic instr_end;
        logic wait_exec;
        logic stop_exec;
        wsps_ctx_t ctx;
    } wsps_core_t;

    typedef struct packed {
        logic valid;
        logic wake_nmi;
        logic run_isr;
        wsps_ctx_t ctx;
    } wsps_resume_t;

    localparam wsps_resume_t RESUME_RST = '{1'b0, 1'b0, 1'b0, CTX_MAIN};

endpackage

// ==== rtl/wsps_sync.sv ====
/*
 * Two-flop level synchroniser for pins entering the main clock domain.
 * Assumes the inputs are slow levels; narrow glitches may be missed.
 */
`timescale 1ns/1ps
module wsps_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;

endmodule // wsps_sync

// ==== rtl/wsps_settle.sv ====
/*
 * Oscillator settling timer started on wake-up from stop.
 * Assumes the counting clock is the restarted main oscillator.
 */
`timescale 1ns/1ps
module wsps_settle #(
    parameter int CYC = 4096
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);

    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] CYC_V = CW'(CYC);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_start) begin
            cnt_d = CYC_V;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - ONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_busy = (cnt_q != '0);
    // last counted cycle; a start while busy reloads the count, the caller does not gate it
    assign o_done = (cnt_q == ONE);

endmodule // wsps_settle

// ==== rtl/wsps_core.sv ====
/*
 * Wait/stop power-saving sequencer: entry, wake-up, settling and resume.
 * Assumes the core pulses instr_end once per instruction with the exec
 * flags and context valid in that cycle, and that peripheral requests
 * are on this clock while the nmi and external request arrive on pins.
 */
// Summary of operation
// RULE1 - wait instruction enters idle at once
// RULE2 - oscillator and peripherals run during wait
// RULE3 - no settling delay leaving wait
// RULE4 - stop becomes wait while watchdog active
// RULE5 - stop halts oscillator, external wake only
// RULE6 - settling delay before first instruction
// RULE7 - ram and registers kept in both states
// RULE8 - reset in sleep runs normal reset
// RULE9 - main context runs waking isr
// RULE10 - nmi context resumes, stays nmi
// RULE11 - irq context plus normal wake resumes
// RULE12 - irq context plus nmi runs nmi first
// RULE13 - global enable clear blocks every wake
// RULE14 - pending enabled request skips sleep instruction
// RULE15 - wake leaves oscillator selection untouched
// RULE16 - software powers peripherals down before stop
// RULE17 - global enable bit four at c8
// RULE18 - requests sampled at instruction end
// RULE19 - settling counter length is a parameter
// RULE20 - single resume pulse carries wake class
`timescale 1ns/1ps
module wsps_core #(
    parameter int SETTLE_CYC = wsps_pkg::SETTLE_CYC,
    parameter int NIRQ = 4
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // core sequencer
    input wire wsps_pkg::wsps_core_t i_core,
    input wire logic i_ior_wr,
    input wire logic [7:0] i_ior_addr,
    input wire logic [7:0] i_ior_data,
    // interrupt sources
    input wire logic [NIRQ-1:0] i_irq_req,
    input wire logic i_nmi_pin,
    input wire logic i_ext_irq_pin,
    // watchdog and oscillator
    input wire logic i_wdg_hw_en,
    input wire logic i_wdg_sw_en,
    input wire logic i_wdg_rst,
    input wire logic [1:0] i_osc_sel,
    // to the core
    output logic o_halt,
    output logic o_skip,
    output logic o_branch,
    output logic o_reset_proc,
    output wsps_pkg::wsps_resume_t o_resume,
    // to the clock system and memories
    output logic o_osc_en,
    output logic o_periph_en,
    output logic o_retain,
    output logic [1:0] o_osc_sel,
    // status
    output logic o_gen,
    output wsps_pkg::wsps_state_t o_state
);

    // ************************************************
    // declarations
    // ************************************************
    wsps_pkg::wsps_state_t st_q;
    wsps_pkg::wsps_state_t st_d;
    wsps_pkg::wsps_ctx_t ctx_q;
    wsps_pkg::wsps_ctx_t ctx_d;
    wsps_pkg::wsps_resume_t res_q;
    wsps_pkg::wsps_resume_t res_d;
    logic gen_q;
    logic gen_d;
    logic wnmi_q;
    logic wnmi_d;
    logic [1:0] osel_q;
    logic [1:0] osel_d;
    logic skip_q;
    logic skip_d;
    logic br_q;
    logic br_d;
    logic rstp_q;
    logic rstp_d;
    // pins, two flops after the pad
    logic [1:0] pin_s;
    logic nmi_s;
    logic ext_s;
    logic wdg_on;
    logic irq_any;
    logic ior_hit;
    logic pend;
    logic wake_wait;
    logic wake_stop;
    logic set_start;
    logic set_busy;
    logic set_done;

    // ************************************************
    // helpers
    // ************************************************
    // waking isr only from main, or nmi breaking into an irq routine
    function automatic logic run_isr(input wsps_pkg::wsps_ctx_t c,
                                     input logic nmi);
        logic r;
        r = 1'b0;
        unique case (c)
            wsps_pkg::CTX_MAIN: r = 1'b1; // RULE9
            wsps_pkg::CTX_NMI: r = 1'b0; // RULE10
            wsps_pkg::CTX_IRQ: r = nmi; // RULE11 RULE12
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic wsps_pkg::wsps_resume_t mk_res(
        input wsps_pkg::wsps_ctx_t c, input logic nmi);
        wsps_pkg::wsps_resume_t r;
        r.valid = 1'b1;
        r.wake_nmi = nmi;
        r.run_isr = run_isr(c, nmi);
        // context to continue in after any isr; never changed by the wake
        r.ctx = c; // RULE10 RULE11 RULE12
        return r;
    endfunction

    // ************************************************
    // pin synchronisers and settle timer
    // ************************************************
    wsps_sync #(
        .W(2)
    ) u_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d({i_nmi_pin, i_ext_irq_pin}),
        .o_q(pin_s)
    );

    assign nmi_s = pin_s[1];
    assign ext_s = pin_s[0];

    wsps_settle #(
        .CYC(SETTLE_CYC)
    ) u_settle (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_start(set_start),
        .o_busy(set_busy),
        .o_done(set_done)
    ); // RULE19

    // ************************************************
    // request qualification
    // ************************************************
    assign wdg_on = i_wdg_hw_en | i_wdg_sw_en;
    assign irq_any = |i_irq_req;
    // ext pin is a maskable request line too, so it also skips sleep
    // nmi is never masked as an interrupt, only as a wake source
    assign pend = nmi_s | (gen_q & (ext_s | irq_any)); // RULE14 RULE18
    // peripherals keep clocking in wait, so their requests count
    assign wake_wait = gen_q & (nmi_s | ext_s | irq_any); // RULE2 RULE13
    // in stop only pins can call, nothing on-chip is clocked
    assign wake_stop = gen_q & (nmi_s | ext_s); // RULE5 RULE13

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        st_d = st_q;
        ctx_d = ctx_q;
        wnmi_d = wnmi_q;
        res_d = wsps_pkg::RESUME_RST;
        skip_d = 1'b0;
        br_d = 1'b0;
        rstp_d = 1'b0;
        set_start = 1'b0;
        unique case (st_q)
            wsps_pkg::ST_RUN: begin
                if (i_core.instr_end) begin
                    if (pend) begin
                        br_d = 1'b1; // RULE18
                        skip_d = i_core.wait_exec | i_core.stop_exec; // RULE14
                    end else if (i_core.stop_exec && !wdg_on) begin
                        st_d = wsps_pkg::ST_STOP; // RULE5
                        ctx_d = i_core.ctx;
                    end else if (i_core.stop_exec || i_core.wait_exec) begin
                        st_d = wsps_pkg::ST_WAIT; // RULE1 RULE4
                        ctx_d = i_core.ctx;
                    end
                end
            end
            wsps_pkg::ST_WAIT: begin
                if (wake_wait) begin
                    // clock never stopped: resume straight away
                    st_d = wsps_pkg::ST_RUN; // RULE3
                    res_d = mk_res(ctx_q, nmi_s); // RULE20
                end
            end
            wsps_pkg::ST_STOP: begin
                // timer loads in the wake cycle and ends on the last settle cycle
                if (wake_stop) begin
                    st_d = wsps_pkg::ST_SETTLE;
                    wnmi_d = nmi_s;
                    set_start = 1'b1; // RULE6
                end
            end
            wsps_pkg::ST_SETTLE: begin
                // a short nmi pulse is remembered from the wake cycle
                // a watchdog reset here abandons the count; the timer runs out idle
                if (set_done) begin
                    st_d = wsps_pkg::ST_RUN; // RULE6
                    res_d = mk_res(ctx_q, wnmi_q); // RULE20
                end
            end
        endcase
        // watchdog reset overrides any wake in progress
        if (i_wdg_rst) begin
            st_d = wsps_pkg::ST_RUN; // RULE8
            ctx_d = wsps_pkg::CTX_MAIN;
            wnmi_d = 1'b0;
            res_d = wsps_pkg::RESUME_RST;
            skip_d = 1'b0;
            br_d = 1'b0;
            rstp_d = 1'b1; // RULE8
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= wsps_pkg::ST_RUN;
            ctx_q <= wsps_pkg::CTX_MAIN;
            wnmi_q <= 1'b0;
            res_q <= wsps_pkg::RESUME_RST;
            skip_q <= 1'b0;
            br_q <= 1'b0;
            rstp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ctx_q <= ctx_d;
            wnmi_q <= wnmi_d;
            res_q <= res_d;
            skip_q <= skip_d;
            br_q <= br_d;
            rstp_q <= rstp_d;
        end
    end

    // ************************************************
    // interrupt option register and oscillator select
    // ************************************************
    // only the enable bit is kept; the edge and level options live elsewhere
    assign ior_hit = i_ior_wr && (i_ior_addr == wsps_pkg::IOR_ADDR);

    always_comb begin
        gen_d = gen_q;
        osel_d = osel_q;
        if (ior_hit) begin
            gen_d = i_ior_data[wsps_pkg::GEN_BIT]; // RULE17
        end
        // selection only follows the core while running
        if (st_q == wsps_pkg::ST_RUN) begin
            osel_d = i_osc_sel;
        end // RULE15
        if (i_wdg_rst) begin
            gen_d = wsps_pkg::GEN_RST; // RULE8 RULE17
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gen_q <= wsps_pkg::GEN_RST;
            osel_q <= 2'h0;
        end else begin
            gen_q <= gen_d;
            osel_q <= osel_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign o_halt = (st_q != wsps_pkg::ST_RUN); // RULE1 RULE5
    // settle phase needs the oscillator up but no instruction yet
    assign o_osc_en = (st_q != wsps_pkg::ST_STOP); // RULE2 RULE5
    assign o_periph_en = (st_q == wsps_pkg::ST_RUN) || (st_q == wsps_pkg::ST_WAIT); // RULE2
    // tells memories and peripheral registers to hold, never clear
    assign o_retain = o_halt; // RULE7
    // pulses are registered: the core sees them one cycle after its request
    assign o_skip = skip_q;
    assign o_branch = br_q;
    assign o_reset_proc = rstp_q;
    assign o_resume = res_q;
    assign o_osc_sel = osel_q;
    assign o_gen = gen_q;
    assign o_state = st_q;

endmodule // wsps_core

// ==== sim/wsps_core_monitor.sv ====
/*
 * Port checks of the power-saving sequencer.
 * Assumes one clock domain and the async active-high reset.
 */
`timescale 1ns/1ps
module wsps_core_monitor #(
    parameter int SETTLE_CYC = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // inputs
    input wire wsps_pkg::wsps_core_t i_core,
    input wire logic i_ior_wr,
    input wire logic [7:0] i_ior_addr,
    input wire logic [7:0] i_ior_data,
    input wire logic i_wdg_hw_en,
    input wire logic i_wdg_sw_en,
    input wire logic i_wdg_rst,
    // outputs
    input wire logic o_skip,
    input wire logic o_branch,
    input wire logic o_retain,
    input wire logic o_osc_en,
    input wire logic [1:0] o_osc_sel,
    input wire logic o_gen,
    input wire wsps_pkg::wsps_resume_t o_resume,
    input wire wsps_pkg::wsps_state_t o_state
);
    // ****************************************
    // settle length counter
    // ****************************************
    int unsigned stl_q;
    int unsigned stl_d;
    always_comb stl_d = (o_state == wsps_pkg::ST_SETTLE) ? stl_q + 1 : 0;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            stl_q <= 0;
        else
            stl_q <= stl_d;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ****************************************
    // properties
    // ****************************************
    property p_entry;
        (o_state == wsps_pkg::ST_WAIT && $past(o_state) == wsps_pkg::ST_RUN)
            |-> $past(i_core.instr_end);
    endproperty
    a_entry: assert property (p_entry) else $error("idle entered without instruction");
    property p_osc;
        o_osc_en == (o_state != wsps_pkg::ST_STOP);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_fast;
        ($past(o_state) == wsps_pkg::ST_WAIT && o_state == wsps_pkg::ST_RUN
            && !$past(i_wdg_rst)) |-> o_resume.valid;
    endproperty
    a_fast: assert property (p_fast) else $error("wait exit without resume");
    property p_stop;
        (o_state == wsps_pkg::ST_STOP && $past(o_state) == wsps_pkg::ST_RUN)
            |-> !$past(i_wdg_hw_en | i_wdg_sw_en);
    endproperty
    a_stop: assert property (p_stop) else $error("stop with watchdog on");
    property p_settle;
        (o_resume.valid && $past(o_state) == wsps_pkg::ST_SETTLE) |-> stl_q == SETTLE_CYC;
    endproperty
    a_settle: assert property (p_settle) else $error("settle length wrong");
    property p_retain;
        o_retain == (o_state != wsps_pkg::ST_RUN);
    endproperty
    a_retain: assert property (p_retain) else $error("retain flag wrong");
    property p_wdg;
        i_wdg_rst |=> o_state == wsps_pkg::ST_RUN && !o_gen;
    endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog reset ignored");
    property p_fields;
        o_resume.valid |-> o_resume.run_isr == (o_resume.ctx == wsps_pkg::CTX_MAIN
            || (o_resume.ctx == wsps_pkg::CTX_IRQ && o_resume.wake_nmi));
    endproperty
    a_fields: assert property (p_fields)
        else $error("resume class wrong");
    property p_block;
        (!o_gen && o_state != wsps_pkg::ST_RUN) |=> !o_resume.valid;
    endproperty
    a_block: assert property (p_block) else $error("wake while disabled");
    property p_skip;
        o_skip |-> $past(i_core.instr_end) && o_state == wsps_pkg::ST_RUN;
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_sel;
        (o_state != wsps_pkg::ST_RUN && $past(o_state) != wsps_pkg::ST_RUN) |-> $stable(o_osc_sel);
    endproperty
    a_sel: assert property (p_sel) else $error("oscillator select moved");
    property p_gen;
        ($past(i_ior_wr) && $past(i_ior_addr) == wsps_pkg::IOR_ADDR && !$past(i_wdg_rst)
            && !$past(i_rst)) |-> o_gen == $past(i_ior_data[wsps_pkg::GEN_BIT]);
    endproperty
    a_gen: assert property (p_gen) else $error("enable write lost");
    property p_branch;
        o_branch |-> $past(i_core.instr_end);
    endproperty
    a_branch: assert property (p_branch) else $error("branch without instruction");
    c_settle: cover property (o_state == wsps_pkg::ST_SETTLE);
    c_skip: cover property (o_skip);
    c_nmi: cover property (o_resume.valid && o_resume.wake_nmi);
endmodule // wsps_core_monitor

bind wsps_core wsps_core_monitor #(.SETTLE_CYC(SETTLE_CYC)) wsps_core_monitor_inst (
    .i_ref_clk, .i_rst, .i_core, .i_ior_wr, .i_ior_addr, .i_ior_data, .i_wdg_hw_en,
    .i_wdg_sw_en, .i_wdg_rst, .o_skip, .o_branch, .o_retain, .o_osc_en, .o_osc_sel,
    .o_gen, .o_resume, .o_state);

// ==== sim/wsps_cpu_model.sv ====
/*
 * Core sequencer stand-in: one instruction end with exec flags.
 * Assumes issue is called from the bench process.
 */
`timescale 1ns/1ps
module wsps_cpu_model (
    // clock
    input wire logic i_ref_clk,
    // to the sequencer
    output wsps_pkg::wsps_core_t o_core
);
    initial o_core = '0;
    // flags stand only with instr_end; peripherals assumed already powered down
    task automatic issue(input logic w, input logic s, input wsps_pkg::wsps_ctx_t c);
        @(posedge i_ref_clk);
        o_core <= '{1'b1, w, s, c};
        @(posedge i_ref_clk);
        o_core <= '0;
    endtask
endmodule // wsps_cpu_model

// ==== sim/wsps_core_bench.sv ====
/*
 * Self-checking bench of the power-saving sequencer.
 * Assumes settle shortened to 8 cycles and the bound checker.
 */
`timescale 1ns/1ps
module wsps_core_bench;
    localparam int SC = 8;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    wsps_pkg::wsps_core_t i_core;
    logic i_ior_wr = 1'b0;
    logic [7:0] i_ior_addr = 8'h00;
    logic [7:0] i_ior_data = 8'h00;
    logic [3:0] i_irq_req = 4'h0;
    logic i_nmi_pin = 1'b0;
    logic i_ext_irq_pin = 1'b0;
    logic i_wdg_hw_en = 1'b0;
    logic i_wdg_sw_en = 1'b0;
    logic i_wdg_rst = 1'b0;
    logic [1:0] i_osc_sel = 2'h1;
    logic o_halt, o_skip, o_branch, o_reset_proc, o_osc_en, o_periph_en, o_retain, o_gen;
    wsps_pkg::wsps_resume_t o_resume;
    logic [1:0] o_osc_sel;
    wsps_pkg::wsps_state_t o_state;
    int err_total = 0;
    int num_checks = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    wsps_cpu_model wsps_cpu_model_inst (.i_ref_clk, .o_core(i_core));
    wsps_core #(.SETTLE_CYC(SC)) wsps_core_inst (.i_ref_clk, .i_rst, .i_core, .i_ior_wr,
        .i_ior_addr, .i_ior_data, .i_irq_req, .i_nmi_pin, .i_ext_irq_pin, .i_wdg_hw_en,
        .i_wdg_sw_en, .i_wdg_rst, .i_osc_sel, .o_halt, .o_skip, .o_branch, .o_reset_proc,
        .o_resume, .o_osc_en, .o_periph_en, .o_retain, .o_osc_sel, .o_gen, .o_state);
    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic interrupt_option_register(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_ior_wr <= 1'b1;
        i_ior_addr <= a;
        i_ior_data <= d;
        @(posedge i_ref_clk);
        i_ior_wr <= 1'b0;
        tick(1);
    endtask
    task automatic wait_res(output int n);
        n = 0;
        while (o_resume.valid !== 1'b1) begin
            tick(1);
            n++;
            if (n > 60) begin
                chk(0, 1);
                end_sim();
            end
        end
    endtask
    task automatic wdg_exit();
        logic seen;
        @(posedge i_ref_clk);
        i_wdg_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_wdg_rst <= 1'b0;
        #1;
        seen = o_reset_proc;
        chk(o_state, wsps_pkg::ST_RUN);
        chk(o_gen, 1'b0);
        tick(1);
        chk(seen | o_reset_proc, 1'b1);
        interrupt_option_register(wsps_pkg::IOR_ADDR, 8'h10);
    endtask
    // sleep, hold, wake by source 0 irq, 1 ext pin, 2 nmi pin; judge resume
    task automatic sleep_wake(input logic stp, input wsps_pkg::wsps_ctx_t c, input int src);
        int n;
        logic [1:0] osel;
        logic nm;
        logic [4:0] rs;
        nm = (src == 2);
        rs = {1'b1, nm, (c == wsps_pkg::CTX_MAIN) || (c == wsps_pkg::CTX_IRQ && nm), c};
        wsps_cpu_model_inst.issue(!stp, stp, c);
        #1;
        chk(o_state, stp ? wsps_pkg::ST_STOP : wsps_pkg::ST_WAIT);
        chk({o_osc_en, o_periph_en}, stp ? 2'h0 : 2'h3);
        chk({o_halt, o_retain}, 2'h3);
        osel = o_osc_sel;
        @(posedge i_ref_clk);
        i_osc_sel <= ~i_osc_sel;
        tick(2);
        chk(o_osc_sel, osel);
        @(posedge i_ref_clk);
        if (src == 0)
            i_irq_req <= 4'h2;
        else if (src == 1)
            i_ext_irq_pin <= 1'b1;
        else
            i_nmi_pin <= 1'b1;
        if (stp) begin
            n = 0;
            while (o_state !== wsps_pkg::ST_SETTLE && n < 20) begin
                tick(1);
                n++;
            end
            chk(o_state, wsps_pkg::ST_SETTLE);
        end
        wait_res(n);
        if (stp)
            chk(n, SC);
        else if (src == 0)
            chk(n, 1);
        chk(o_resume, rs);
        chk(o_state, wsps_pkg::ST_RUN);
        @(posedge i_ref_clk);
        i_irq_req <= 4'h0;
        i_ext_irq_pin <= 1'b0;
        i_nmi_pin <= 1'b0;
        tick(4);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_gen();
        tick(1);
        chk({o_gen, o_state, o_halt, o_osc_en, o_resume}, 10'h020);
        interrupt_option_register(8'hc9, 8'h10);
        chk(o_gen, 1'b0);
        interrupt_option_register(wsps_pkg::IOR_ADDR, 8'h10);
        chk(o_gen, 1'b1);
        $display("test reset_gen done");
    endtask
    task automatic t_skip();
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk);
            i_irq_req <= 4'h1;
            wsps_cpu_model_inst.issue(k == 0, k == 1, wsps_pkg::CTX_MAIN);
            #1;
            chk({o_skip, o_branch}, 2'h3);
            chk(o_state, wsps_pkg::ST_RUN);
            @(posedge i_ref_clk);
            i_irq_req <= 4'h0;
        end
        $display("test skip done");
    endtask
    task automatic t_ctx();
        sleep_wake(1'b0, wsps_pkg::CTX_MAIN, 0);
        sleep_wake(1'b0, wsps_pkg::CTX_IRQ, 0);
        sleep_wake(1'b0, wsps_pkg::CTX_IRQ, 2);
        sleep_wake(1'b1, wsps_pkg::CTX_NMI, 1);
        sleep_wake(1'b1, wsps_pkg::CTX_IRQ, 2);
        sleep_wake(1'b1, wsps_pkg::CTX_MAIN, 1);
        $display("test ctx done");
    endtask
    task automatic t_wdg();
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk);
            i_wdg_hw_en <= (k == 0);
            i_wdg_sw_en <= (k == 1);
            wsps_cpu_model_inst.issue(1'b0, 1'b1, wsps_pkg::CTX_MAIN);
            #1;
            chk(o_state, wsps_pkg::ST_WAIT);
            wdg_exit();
        end
        @(posedge i_ref_clk);
        i_wdg_sw_en <= 1'b0;
        $display("test wdg done");
    endtask
    // pin reset in stop: ordinary reset, no resume
    task automatic t_pin_rst();
        wsps_cpu_model_inst.issue(1'b0, 1'b1, wsps_pkg::CTX_MAIN);
        #1;
        chk(o_state, wsps_pkg::ST_STOP);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        tick(2);
        chk({o_state, o_halt, o_osc_en, o_gen}, 5'h02);
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        tick(2);
        chk({o_state, o_halt, o_resume.valid}, 4'h0);
        interrupt_option_register(wsps_pkg::IOR_ADDR, 8'h10);
        chk(o_gen, 1'b1);
        $display("test pin_rst done");
    endtask
    task automatic t_gen_off();
        interrupt_option_register(wsps_pkg::IOR_ADDR, 8'h00);
        wsps_cpu_model_inst.issue(1'b1, 1'b0, wsps_pkg::CTX_MAIN);
        @(posedge i_ref_clk);
        i_irq_req <= 4'h8;
        i_ext_irq_pin <= 1'b1;
        i_nmi_pin <= 1'b1;
        tick(10);
        chk({o_state, o_resume.valid}, 3'h2);
        wdg_exit();
        @(posedge i_ref_clk);
        i_irq_req <= 4'h0;
        i_ext_irq_pin <= 1'b0;
        i_nmi_pin <= 1'b0;
        tick(4);
        $display("test gen_off done");
    endtask
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_reset_gen();
        t_skip();
        t_ctx();
        t_wdg();
        t_gen_off();
        t_pin_rst();
        end_sim();
    end
endmodule // wsps_core_bench
